// >>> hdl/scb_pkg.sv
// package: register map, field layout, reset values and timing for the servo card bus interface
package scb_pkg;

  // register byte offsets (one aligned word each)
  localparam logic [7:0] DAC_PRESSURE_OFS = 8'h00;
  localparam logic [7:0] DAC_FLOW_OFS     = 8'h04;
  localparam logic [7:0] DAC_STOP_OFS     = 8'h08;
  localparam logic [7:0] DAC_VELOCITY_OFS = 8'h0c;
  localparam logic [7:0] MUX_SELECT_OFS   = 8'h10;
  localparam logic [7:0] ADC_RESULT_OFS   = 8'h14;
  localparam logic [7:0] HEAD_STATUS_OFS  = 8'h18;
  localparam logic [7:0] HEAD_CONTROL_OFS = 8'h1c;
  localparam logic [7:0] WDOG_KICK_OFS    = 8'h20;
  localparam logic [7:0] IRQ_STATUS_OFS   = 8'h24;
  localparam logic [7:0] IRQ_MASK_OFS     = 8'h28;
  localparam logic [7:0] ALARM_OFS        = 8'h2c;

  // widths
  localparam int DAC_W     = 8;
  localparam int ADC_W     = 10;
  localparam int MUX_SEL_W = 3;
  localparam int DAC_NUM   = 4;

  // dac scale: 40 mV per code, full range 10 V
  localparam int DAC_STEP_MV  = 40;
  localparam int DAC_RANGE_MV = 10000;

  // mux input assignment
  localparam logic [2:0] MUX_IN_PRESSURE = 3'h0;
  localparam logic [2:0] MUX_IN_FLOW     = 3'h1;
  localparam logic [2:0] MUX_IN_STOP     = 3'h2;
  localparam logic [2:0] MUX_IN_REF10V   = 3'h3;
  localparam logic [2:0] MUX_IN_PLUNGER  = 3'h4;

  // head status bit positions
  localparam int ST_TURRET   = 0;
  localparam int ST_SYR60    = 1;
  localparam int ST_FWDREV   = 2;
  localparam int ST_DRVFAULT = 3;
  localparam int ST_OVERP    = 4;

  // head control field layout
  localparam int CT_FLOW_LSB  = 0;
  localparam int CT_FLOW_W    = 2;
  localparam int CT_SAFERELAY = 2;
  localparam int CT_OVERRIDE  = 3;

  // irq event bits
  localparam int EV_ADC_DONE = 0;
  localparam int EV_ALARM    = 1;
  localparam int EV_NUM      = 2;

  // alarm cause bits
  localparam int AL_WDOG  = 0;
  localparam int AL_OVERP = 1;
  localparam int AL_DRV   = 2;

  // reset values
  localparam logic [7:0] DAC_RESET  = 8'h00;
  localparam logic [3:0] CTRL_RESET = 4'h0;

  // watchdog timeout and mux settle time
  localparam int WDOG_TIMEOUT_US = 100;
  localparam int CLK_MHZ         = 100;
  localparam int WDOG_CYCLES     = WDOG_TIMEOUT_US * CLK_MHZ;
  localparam int SETTLE_NS       = 50;
  localparam int CLK_NS          = 10;
  localparam int SETTLE_CYCLES   = (SETTLE_NS + CLK_NS - 1) / CLK_NS;

  // ahb transfer descriptor latched in the address phase
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } scb_ahb_req_t;

  // head inputs that the status port shows
  typedef struct packed {
    logic overpressureAlarm;
    logic driveFault;
    logic fwdRev;
    logic syringe60;
    logic turret;
  } scb_head_in_t;

  // host-written head outputs
  typedef struct packed {
    logic       systemOverride;
    logic       safeRelayEnable;
    logic [1:0] flowControl;
  } scb_head_out_t;

  // converter sequencer states
  typedef enum logic [2:0] {
    ADC_IDLE   = 3'b001,
    ADC_SETTLE = 3'b010,
    ADC_CONV   = 3'b100
  } scb_adc_state_t;

endpackage

// >>> hdl/scb_watchdog.sv
// stop-position watchdog: counts down, reloads on each retrigger pulse
`timescale 1ns/1ps
`default_nettype none
module scb_watchdog #(
  parameter int TIMEOUT = scb_pkg::WDOG_CYCLES
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // retrigger and expiry
  input  wire logic kick,
  output logic      expired
);

  typedef struct packed {
    logic [31:0] count;
    logic        expired;
  } scb_wdog_state_t;

  scb_wdog_state_t st;
  scb_wdog_state_t next_st;

  // reload on kick, otherwise count down to expiry
  always_comb begin
    next_st = st;
    if (kick) begin
      next_st.count = 32'(TIMEOUT);
      next_st.expired = 1'b0;
    end else if (st.count != 32'h0) begin
      next_st.count = st.count - 32'h1;
    end else begin
      next_st.expired = 1'b1; // pulses ceased
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{count: 32'(TIMEOUT), expired: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign expired = st.expired;

endmodule // scb_watchdog
`default_nettype wire

// >>> hdl/scb_servo_card.sv
// servo card bus interface: ahb-lite slave, dacs, mux, converter control, status port, alarm latch
// Operation
// - direction logic steers data-bus buffer direction
// - result driven on reads only, else undriven
// - start conversion when input ready, gate result
// - separate write enables per dac and mux
// - decoder strobes converter, direction, watchdog retrigger
// - retrigger only when stop positioned and ready
// - late stop stops pulses, watchdog disarms
// - status port reads head and drive inputs
// - flow control, relay, override held until rewritten
// - alarm on watchdog, overpressure or drive fault
// - one dac captures one byte per write
// - byte code maps linearly, 40 mV steps
// - channels: pressure, flow, stop, velocity
// - eight-input mux under latched select timing
// - ten volt reference is a mux input
// - plunger position pot is a mux input
//
// Local design decisions: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module scb_servo_card #(
  parameter int WDOG_TIMEOUT = scb_pkg::WDOG_CYCLES
) (
  // clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          rst_n,
  // ahb-lite slave
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic      [31:0]                   hrdata,
  output logic                               hreadyout,
  output logic                               hresp,
  // card data-bus buffer direction and result gate
  output logic                               busDirOut,
  output logic                               resultOe,
  // dac codes
  output logic      [scb_pkg::DAC_W-1:0]     pressureCapLevel,
  output logic      [scb_pkg::DAC_W-1:0]     flowRateLevel,
  output logic      [scb_pkg::DAC_W-1:0]     stopPositionLevel,
  output logic      [scb_pkg::DAC_W-1:0]     velocityLevel,
  output logic      [3:0]                    dacLoad,
  // analog mux and converter
  output logic      [scb_pkg::MUX_SEL_W-1:0] muxSelect,
  output logic                               adcStart,
  input  wire logic                          adcDone,
  input  wire logic [scb_pkg::ADC_W-1:0]     adcData,
  // head and drive signals
  input  wire scb_pkg::scb_head_in_t         headIn,
  input  wire logic                          stopInPosition,
  input  wire logic                          readyToInject,
  output scb_pkg::scb_head_out_t             headOut,
  // alarm and interrupt
  output logic                               disarm,
  output logic                               irq
);

  typedef struct packed {
    scb_pkg::scb_ahb_req_t                req;
    logic [3:0][scb_pkg::DAC_W-1:0]       dac;
    logic [3:0]                           dacLoad;
    logic [scb_pkg::MUX_SEL_W-1:0]        muxSel;
    scb_pkg::scb_adc_state_t              adcState;
    logic [3:0]                           settle;
    logic                                 adcStart;
    logic [scb_pkg::ADC_W-1:0]            result;
    scb_pkg::scb_head_out_t               headOut;
    logic [2:0]                           alarm;
    logic [scb_pkg::EV_NUM-1:0]           irqStatus;
    logic [scb_pkg::EV_NUM-1:0]           irqMask;
    logic                                 kick;
    logic [31:0]                          rdata;
    logic                                 dirOut;
  } scb_state_t;

  scb_state_t st;
  scb_state_t next_st;
  logic       wdogExpired;

  // a register hit in the given phase
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // dac code to millivolts, linear 40 mV per count
  function automatic int codeToMv(input logic [scb_pkg::DAC_W-1:0] code);
    return int'(code) * scb_pkg::DAC_STEP_MV;
  endfunction

  // address phase: only nonseq/seq with hready are taken
  logic addrTaken;
  assign addrTaken = hsel && hready && htrans[1];

  // next-state logic for the whole card
  always_comb begin
    logic [7:0] a;
    logic       wr;
    logic       rd;
    logic [2:0] cause;
    logic [scb_pkg::EV_NUM-1:0] ev;
    a = st.req.addr;
    wr = st.req.valid && st.req.write;
    rd = addrTaken && !hwrite;
    cause = 3'h0;
    ev = '0;
    next_st = st;
    next_st.dacLoad = 4'h0;
    next_st.adcStart = 1'b0;
    next_st.kick = 1'b0;
    next_st.req.valid = addrTaken;
    next_st.req.write = hwrite;
    next_st.req.addr = haddr[7:0];
    // direction logic: drive host bus only in a read data phase
    next_st.dirOut = rd;

    // decoded writes: each target has its own enable
    if (wr) begin
      if (hit(a, scb_pkg::DAC_PRESSURE_OFS)) begin
        next_st.dac[0] = hwdata[scb_pkg::DAC_W-1:0];
        next_st.dacLoad[0] = 1'b1;
      end
      if (hit(a, scb_pkg::DAC_FLOW_OFS)) begin
        next_st.dac[1] = hwdata[scb_pkg::DAC_W-1:0];
        next_st.dacLoad[1] = 1'b1;
      end
      if (hit(a, scb_pkg::DAC_STOP_OFS)) begin
        next_st.dac[2] = hwdata[scb_pkg::DAC_W-1:0];
        next_st.dacLoad[2] = 1'b1;
      end
      if (hit(a, scb_pkg::DAC_VELOCITY_OFS)) begin
        next_st.dac[3] = hwdata[scb_pkg::DAC_W-1:0];
        next_st.dacLoad[3] = 1'b1;
      end
      if (hit(a, scb_pkg::MUX_SELECT_OFS)) begin
        next_st.muxSel = hwdata[scb_pkg::MUX_SEL_W-1:0];
        next_st.adcState = scb_pkg::ADC_SETTLE;
        next_st.settle = 4'(scb_pkg::SETTLE_CYCLES);
      end
      if (hit(a, scb_pkg::HEAD_CONTROL_OFS)) begin
        next_st.headOut.flowControl = hwdata[scb_pkg::CT_FLOW_LSB +: scb_pkg::CT_FLOW_W];
        next_st.headOut.safeRelayEnable = hwdata[scb_pkg::CT_SAFERELAY];
        next_st.headOut.systemOverride = hwdata[scb_pkg::CT_OVERRIDE];
      end
      if (hit(a, scb_pkg::WDOG_KICK_OFS)) begin
        next_st.kick = stopInPosition && readyToInject;
      end
      if (hit(a, scb_pkg::IRQ_MASK_OFS)) begin
        next_st.irqMask = hwdata[scb_pkg::EV_NUM-1:0];
      end
    end

    // converter sequencer: settle mux, start, capture result
    case (st.adcState)
      scb_pkg::ADC_IDLE: begin
        next_st.adcState = next_st.adcState;
      end
      scb_pkg::ADC_SETTLE: begin
        if (next_st.adcState == scb_pkg::ADC_SETTLE && st.settle != 4'h0 && next_st.settle == st.settle) begin
          next_st.settle = st.settle - 4'h1;
        end else if (next_st.settle == st.settle) begin
          next_st.adcStart = 1'b1; // input ready, start
          next_st.adcState = scb_pkg::ADC_CONV;
        end
      end
      scb_pkg::ADC_CONV: begin
        if (adcDone) begin
          next_st.result = adcData;
          ev[scb_pkg::EV_ADC_DONE] = 1'b1;
          if (next_st.adcState == scb_pkg::ADC_CONV) begin
            next_st.adcState = scb_pkg::ADC_IDLE;
          end
        end
      end
      default: begin
        next_st.adcState = scb_pkg::ADC_IDLE;
      end
    endcase

    // alarm latch: sticky until reset
    cause[scb_pkg::AL_WDOG] = wdogExpired;
    cause[scb_pkg::AL_OVERP] = headIn.overpressureAlarm;
    cause[scb_pkg::AL_DRV] = headIn.driveFault;
    next_st.alarm = st.alarm | cause;
    if (cause != 3'h0) begin
      ev[scb_pkg::EV_ALARM] = 1'b1;
    end
    // sticky event bits: new events or onto what is already held
    next_st.irqStatus = st.irqStatus | ev;

    // read data and read side effects
    next_st.rdata = 32'h0;
    if (rd) begin
      case (haddr[7:0])
        scb_pkg::DAC_PRESSURE_OFS: next_st.rdata = {24'h0, st.dac[0]};
        scb_pkg::DAC_FLOW_OFS:     next_st.rdata = {24'h0, st.dac[1]};
        scb_pkg::DAC_STOP_OFS:     next_st.rdata = {24'h0, st.dac[2]};
        scb_pkg::DAC_VELOCITY_OFS: next_st.rdata = {24'h0, st.dac[3]};
        scb_pkg::MUX_SELECT_OFS:   next_st.rdata = {29'h0, st.muxSel};
        scb_pkg::ADC_RESULT_OFS:   next_st.rdata = {22'h0, next_st.result};
        scb_pkg::HEAD_STATUS_OFS:  next_st.rdata = {27'h0, headIn};
        scb_pkg::HEAD_CONTROL_OFS: next_st.rdata = {28'h0, st.headOut};
        scb_pkg::IRQ_STATUS_OFS: begin
          next_st.rdata = {30'h0, st.irqStatus};
          // clear on read, but an event this cycle still sets
          next_st.irqStatus = ev;
        end
        scb_pkg::IRQ_MASK_OFS:     next_st.rdata = {30'h0, st.irqMask};
        scb_pkg::ALARM_OFS:        next_st.rdata = {29'h0, st.alarm};
        default:                   next_st.rdata = 32'h0;
      endcase
    end
  end

  // state register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st.req       <= '0;
      st.dac       <= {4{scb_pkg::DAC_RESET}};
      st.dacLoad   <= 4'h0;
      st.muxSel    <= '0;
      st.adcState  <= scb_pkg::ADC_IDLE;
      st.settle    <= 4'h0;
      st.adcStart  <= 1'b0;
      st.result    <= '0;
      st.headOut   <= scb_pkg::CTRL_RESET;
      st.alarm     <= 3'h0;
      st.irqStatus <= '0;
      st.irqMask   <= '0;
      st.kick      <= 1'b0;
      st.rdata     <= 32'h0;
      st.dirOut    <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // stop-position watchdog
  scb_watchdog #(
    .TIMEOUT (WDOG_TIMEOUT)
  ) u_wdog (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .kick     (st.kick),
    .expired  (wdogExpired)
  );

  // bus answers: zero wait, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = st.rdata;

  // buffer controls: result gate only while a result read is in its data phase
  assign busDirOut = st.dirOut;
  assign resultOe  = st.dirOut && st.req.addr == scb_pkg::ADC_RESULT_OFS;

  // outputs
  assign pressureCapLevel  = st.dac[0];
  assign flowRateLevel     = st.dac[1];
  assign stopPositionLevel = st.dac[2];
  assign velocityLevel     = st.dac[3];
  assign dacLoad           = st.dacLoad;
  assign muxSelect         = st.muxSel;
  assign adcStart          = st.adcStart;
  assign headOut           = st.headOut;
  assign disarm            = st.alarm != 3'h0;
  assign irq               = |(st.irqStatus & st.irqMask);

endmodule // scb_servo_card
`default_nettype wire

// >>> tb/scb_servo_card_properties.sv
// checker: concurrent properties on the servo card bus interface ports
`timescale 1ns/1ps
`default_nettype none
module scb_servo_card_properties (
  // clock and reset
  input wire logic                      core_clk,
  input wire logic                      rst_n,
  // host bus
  input wire logic                      hsel,
  input wire logic [31:0]               haddr,
  input wire logic [1:0]                htrans,
  input wire logic                      hwrite,
  input wire logic [31:0]               hwdata,
  input wire logic                      hready,
  input wire logic                      hreadyout,
  input wire logic                      hresp,
  // card outputs and head inputs
  input wire logic                      busDirOut,
  input wire logic                      resultOe,
  input wire logic [scb_pkg::DAC_W-1:0] flowRateLevel,
  input wire logic [3:0]                dacLoad,
  input wire logic                      adcStart,
  input wire scb_pkg::scb_head_in_t     headIn,
  input wire scb_pkg::scb_head_out_t    headOut,
  input wire logic                      disarm
);
  logic       taken, rdTaken, wrTaken, rdResult, wrFlow, wrMux, wrCtl;
  logic [7:0] wByte;
  // requests decoded from the address phase
  assign taken    = hsel && hready && htrans[1];
  assign rdTaken  = taken && !hwrite;
  assign wrTaken  = taken && hwrite;
  assign rdResult = rdTaken && haddr[7:0] == scb_pkg::ADC_RESULT_OFS;
  assign wrFlow   = wrTaken && haddr[7:0] == scb_pkg::DAC_FLOW_OFS;
  assign wrMux    = wrTaken && haddr[7:0] == scb_pkg::MUX_SELECT_OFS;
  assign wrCtl    = wrTaken && haddr[7:0] == scb_pkg::HEAD_CONTROL_OFS;
  assign wByte    = hwdata[7:0];

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  bus_okay_a: assert property (hreadyout && !hresp) else $error("bus answer not ready and okay");
  dir_read_a: assert property (rdTaken |=> busDirOut) else $error("buffer not turned outward on read");
  dir_write_a: assert property (wrTaken |=> !busDirOut) else $error("buffer outward on write");
  result_gate_a: assert property (resultOe == $past(rdResult)) else $error("result gate misplaced");
  dac_capture_a: assert property (wrFlow |-> ##2 (flowRateLevel == $past(wByte) && dacLoad == 4'h2))
    else $error("flow channel did not take the byte alone");
  conv_start_a: assert property (wrMux |-> ##[2:16] adcStart) else $error("no conversion start after select");
  head_hold_a: assert property ($changed(headOut) |-> $past(wrCtl, 2)) else $error("head outputs moved");
  alarm_hold_a: assert property (disarm |=> disarm) else $error("alarm dropped before reset");
  overp_alarm_a: assert property (headIn.overpressureAlarm |-> ##[0:3] disarm) else $error("no disarm");
endmodule // scb_servo_card_properties

bind scb_servo_card scb_servo_card_properties u_props (.core_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hreadyout, .hresp, .busDirOut, .resultOe, .flowRateLevel, .dacLoad, .adcStart, .headIn,
  .headOut, .disarm);
`default_nettype wire

// >>> tb/scb_converter_model.sv
// converter model: answers each start pulse with a done pulse and a result word
`timescale 1ns/1ps
`default_nettype none
module scb_converter_model (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // converter handshake
  input  wire logic       adcStart,
  input  wire logic       slow,
  input  wire logic [9:0] sampleCode,
  output logic            adcDone,
  output logic      [9:0] adcData
);
  int         cnt;
  logic [9:0] last;
  // conversion delay; idle data lines show the inverse of the last word
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt     <= 0;
      adcDone <= 1'b0;
      adcData <= 10'h0;
      last    <= 10'h0;
    end else begin
      adcDone <= 1'b0;
      adcData <= ~last;
      if (adcStart) begin
        cnt <= slow ? 9 : 2;
      end else if (cnt == 1) begin
        adcDone <= 1'b1;
        adcData <= sampleCode;
        last    <= sampleCode;
        cnt     <= 0;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule // scb_converter_model
`default_nettype wire

// >>> tb/test_servo_card_bus_interface.sv
// testbench: drives the servo card over the host bus and judges its outputs
`timescale 1ns/1ps
`default_nettype none
module test_servo_card_bus_interface;
  // host bus, head signals and bookkeeping
  logic                   core_clk = 1'b0;
  logic                   rst_n = 1'b0;
  logic                   hsel = 1'b0;
  logic                   hwrite = 1'b0;
  logic [1:0]             htrans = 2'h0;
  logic [2:0]             hsize = 3'h2;
  logic [31:0]            haddr = 32'h0;
  logic [31:0]            hwdata = 32'h0;
  logic [31:0]            hrdata;
  logic                   hreadyout, hresp, busDirOut, resultOe, adcStart, adcDone, disarm, irq;
  logic                   stopInPosition = 1'b0, readyToInject = 1'b0, slow = 1'b0;
  logic [9:0]             sampleCode = 10'h0, adcData;
  logic [7:0]             lvl [4];
  logic [3:0]             dacLoad;
  logic [2:0]             muxSelect;
  scb_pkg::scb_head_in_t  headIn = '0;
  scb_pkg::scb_head_out_t headOut;
  int                     mismatches = 0, tests_run = 0, cycles = 0;

  // clock and run-length guard
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      complete_run();
    end
  end

  // device with a short watchdog, and the converter behind the mux
  scb_servo_card #(.WDOG_TIMEOUT(50)) dut (.core_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .busDirOut, .resultOe, .pressureCapLevel(lvl[0]),
    .flowRateLevel(lvl[1]), .stopPositionLevel(lvl[2]), .velocityLevel(lvl[3]), .dacLoad, .muxSelect, .adcStart,
    .adcDone, .adcData, .headIn, .stopInPosition, .readyToInject, .headOut, .disarm, .irq);
  scb_converter_model u_conv (.core_clk, .rst_n, .adcStart, .slow, .sampleCode, .adcDone, .adcData);

  task automatic complete_run();
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR time %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one single-word transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
  endtask

  // each channel takes only its own low byte; an unmapped write changes nothing
  task automatic t_dacs();
    logic [7:0] e [4];
    for (int j = 0; j < 4; j++) e[j] = scb_pkg::DAC_RESET;
    for (int i = 0; i < 5; i++) begin
      wr(i < 4 ? 8'(4 * i) : 8'h30, {24'hffffff, 8'h5a ^ 8'(i)});
      if (i < 4) e[i] = 8'h5a ^ 8'(i);
      for (int j = 0; j < 4; j++) chk(32'(lvl[j]), 32'(e[j]));
    end
    rd(8'h30, 32'h0, 32'hffffffff);
  endtask

  // status inputs read back; control outputs hold until rewritten
  task automatic t_head();
    headIn <= 5'h0b;
    repeat (3) @(posedge core_clk);
    rd(scb_pkg::HEAD_STATUS_OFS, 32'h0b, 32'h1f);
    headIn <= 5'h04;
    repeat (3) @(posedge core_clk);
    rd(scb_pkg::HEAD_STATUS_OFS, 32'h04, 32'h1f);
    wr(scb_pkg::HEAD_CONTROL_OFS, 32'hd);
    chk(32'(headOut), 32'hd);
    wr(scb_pkg::DAC_FLOW_OFS, 32'h77);
    repeat (20) @(posedge core_clk);
    chk(32'(headOut), 32'hd);
    wr(scb_pkg::HEAD_CONTROL_OFS, 32'h2);
    chk(32'(headOut), 32'h2);
  endtask

  // every mux input converted, read back and its event cleared
  task automatic t_adc();
    int         n;
    logic [9:0] code;
    for (int s = 0; s < 8; s++) begin
      code = 10'h2a5 ^ 10'(s * 73);
      sampleCode <= code;
      slow       <= s[0];
      wr(scb_pkg::IRQ_MASK_OFS, {31'h0, s != 0});
      wr(scb_pkg::MUX_SELECT_OFS, 32'(s));
      chk(32'(muxSelect), 32'(s));
      for (n = 0; n < 100 && adcDone !== 1'b1; n++) begin
        @(posedge core_clk);
      end
      repeat (3) @(posedge core_clk);
      chk(32'(irq), 32'(s != 0));
      rd(scb_pkg::ADC_RESULT_OFS, 32'(code), 32'hffffffff);
      rd(scb_pkg::IRQ_STATUS_OFS, 32'h1, 32'h1);
      rd(scb_pkg::IRQ_STATUS_OFS, 32'h0, 32'h1);
      chk(32'(irq), 32'h0);
    end
  endtask

  // kicks count only with the stop in place and ready; a lapse disarms for good
  task automatic t_wdog();
    do_reset();
    stopInPosition <= 1'b1;
    readyToInject  <= 1'b1;
    repeat (8) begin
      wr(scb_pkg::WDOG_KICK_OFS, 32'h1);
      repeat (16) @(posedge core_clk);
    end
    chk(32'(disarm), 32'h0);
    readyToInject <= 1'b0;
    repeat (5) begin
      wr(scb_pkg::WDOG_KICK_OFS, 32'h1);
      repeat (16) @(posedge core_clk);
    end
    chk(32'(disarm), 32'h1);
    rd(scb_pkg::ALARM_OFS, 32'h1, 32'h1);
    readyToInject <= 1'b1;
    wr(scb_pkg::WDOG_KICK_OFS, 32'h1);
    repeat (60) @(posedge core_clk);
    chk(32'(disarm), 32'h1);
  endtask

  // overpressure and drive fault each latch their own cause
  task automatic t_faults();
    for (int c = 0; c < 2; c++) begin
      do_reset();
      wr(scb_pkg::IRQ_MASK_OFS, 32'h2);
      chk(32'(irq), 32'h0);
      headIn <= (c == 0) ? 5'h10 : 5'h08;
      repeat (3) @(posedge core_clk);
      headIn <= 5'h00;
      repeat (3) @(posedge core_clk);
      chk(32'(disarm), 32'h1);
      rd(scb_pkg::ALARM_OFS, 32'h1 << (c == 0 ? scb_pkg::AL_OVERP : scb_pkg::AL_DRV), 32'h6);
      chk(32'(irq), 32'h1);
      rd(scb_pkg::IRQ_STATUS_OFS, 32'h2, 32'h2);
    end
  endtask

  // main sequence
  initial begin
    do_reset();
    t_dacs();
    t_head();
    t_adc();
    t_wdog();
    t_faults();
    complete_run();
  end
endmodule // test_servo_card_bus_interface
`default_nettype wire
